// ---- verilog/smi_irq_pin_ctrl.sv ----
// smi_irq_pin_ctrl: input enables, group thresholds, wetting current selection and
// the open-drain interrupt line with static or dynamic assertion and idle holdoff.
// assumes: spi pins and comparator outputs are asynchronous; misc_event_i is a
// same-clock pulse from the other monitors; the host stops operation before config.
//
// How it works
// R01 - a disabled input gets no wetting current and its status stops updating
// R02 - after reset every input is disabled
// R03 - one threshold selection is shared by each group of four inputs
// R04 - the threshold code selects one of four levels: 2V, 2.7V, 3V, 4V
// R05 - host sets battery-switch thresholds above the open-switch sink drop
// R06 - wetting current code selects one of six settings, others map to 0 mA
// R07 - after reset every wetting current setting is 0 mA
// R08 - interrupt line is active-low open-drain, pulled low only on events
// R09 - scheme bit 0 selects static level, 1 selects dynamic toggling
// R10 - static: line stays low until chip-select rises after a status read
// R11 - status is captured on the first serial clock rise after chip-select falls
// R12 - a read command to the status register clears it
// R13 - dynamic: low for active time, released for inactive time, repeat until read
// R14 - dynamic: a read while low releases the line and clears at chip-select rise
// R15 - dynamic: a read while released clears and the line stays released
// R16 - after reset the static scheme is selected
// R17 - scheme changes only while the run bit is 0
// R18 - a status read with an event pending starts the idle holdoff
// R19 - events during holdoff update status but the line stays released
// R20 - a read during holdoff clears status, so no assertion when holdoff ends
// R21 - host clears the run bit before changing input configuration
// R22 - active, inactive and holdoff durations are cycle-count parameters
`timescale 1ns/100ps
`default_nettype none
module smi_irq_pin_ctrl
    import smi_pkg::*;
#(
    parameter int N_IN         = smi_pkg::SMI_N_IN,
    parameter int ACTIVE_CYC   = smi_pkg::SMI_ACTIVE_CYC_DEF,
    parameter int INACTIVE_CYC = smi_pkg::SMI_INACTIVE_CYC_DEF,
    parameter int IDLE_CYC     = smi_pkg::SMI_IDLE_CYC_DEF
) (
    // clock and reset
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_i,
    // configuration
    input  wire logic                                   run_i,
    input  wire logic                                   scheme_i,
    input  wire logic [N_IN-1:0]                        switch_en_i,
    input  wire logic [N_IN-1:0]                        irq_en_i,
    input  wire logic [N_IN/smi_pkg::SMI_GRP_SIZE*smi_pkg::SMI_TH_W-1:0] group_threshold_select_i,
    input  wire logic [N_IN/2*smi_pkg::SMI_WC_W-1:0]    wetting_current_cfg_lo_i,
    input  wire logic [N_IN/2*smi_pkg::SMI_WC_W-1:0]    wetting_current_cfg_hi_i,
    // pins and events
    input  wire logic [N_IN-1:0]                        switch_input_i,
    input  wire smi_pkg::smi_spi_t                      spi_i,
    input  wire logic                                   misc_event_i,
    // interrupt pin
    output smi_pkg::smi_od_pin_t                        irq_pin_o,
    // analog front-end control
    output logic      [N_IN-1:0]                        wet_on_o,
    output logic      [N_IN*smi_pkg::SMI_WC_W-1:0]      wet_sel_o,
    output logic      [N_IN*smi_pkg::SMI_TH_W-1:0]      thresh_sel_o,
    // status
    output logic      [N_IN-1:0]                        sw_state_o,
    output logic      [N_IN:0]                          int_stat_o,
    output logic      [N_IN:0]                          stat_snap_o
);

    import smi_pkg::*;

    // ------------------------------------------------------------
    // types and state
    // ------------------------------------------------------------
    localparam int N_GRP = N_IN / SMI_GRP_SIZE;
    localparam int BC_W  = $clog2(SMI_CMD_BITS + 1);

    typedef enum logic [1:0] {
        ST_REL,
        ST_LOW,
        ST_HIGH,
        ST_HOLD
    } smi_irq_st_t;

    typedef struct packed {
        smi_irq_st_t               st;
        logic [SMI_CNT_W-1:0]      cnt;
        logic                      scheme;
        logic [N_IN-1:0]           en;
        logic [N_IN-1:0]           ien;
        logic [N_GRP*SMI_TH_W-1:0] thr;
        logic [N_IN*SMI_WC_W-1:0]  wc;
        logic [N_IN-1:0]           sw;
        logic [N_IN:0]             stat;
        logic [N_IN:0]             snap;
        logic [SMI_CMD_BITS-1:0]   cmd;
        logic [BC_W-1:0]           bit_cnt;
        logic                      rd_hit;
        logic                      int_out;
        logic                      int_oe;
        logic [N_IN-1:0]           wet_on;
        logic [N_IN*SMI_WC_W-1:0]  wc_out;
        logic [N_IN*SMI_TH_W-1:0]  thr_out;
    } smi_st_t;

    smi_st_t q;
    smi_st_t next_q;

    logic [N_IN-1:0] sw_sync;
    logic [2:0]      spi_lvl;
    logic [2:0]      spi_rise;
    logic [2:0]      spi_fall;
    logic            rd_done;
    logic            cnt_zero;
    logic [N_IN:0]   set_bits;
    logic [N_IN-1:0] chg;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [SMI_WC_W-1:0] wc_fix(input logic [SMI_WC_W-1:0] c);
        // an illegal code falls back to no current rather than an undefined source
        return (c > SMI_WC_15MA) ? SMI_WC_0MA : c;
    endfunction : wc_fix

    function automatic logic is_stat_read(input logic [SMI_CMD_BITS-1:0] c);
        return (c[SMI_CMD_BITS-1] == SMI_CMD_READ) &&
               (c[SMI_ADDR_W-1:0] == SMI_STAT_ADDR);
    endfunction : is_stat_read

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    smi_sync #(.W(N_IN)) u_sw_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .d_i    (switch_input_i),
        .q_o    (sw_sync),
        .rise_o (),
        .fall_o ()
    );

    smi_sync #(.W(3)) u_spi_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .d_i    ({spi_i.cs_n, spi_i.sclk, spi_i.mosi}),
        .q_o    (spi_lvl),
        .rise_o (spi_rise),
        .fall_o (spi_fall)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_q   = q;
        rd_done  = 1'b0;
        cnt_zero = (q.cnt == '0);
        chg      = '0;
        // config is only taken while stopped, so nothing changes mid-operation
        if (!run_i) begin
            next_q.scheme = scheme_i;                         // see R17
            next_q.en     = switch_en_i;
            next_q.ien    = irq_en_i;
            next_q.thr    = group_threshold_select_i;
            next_q.wc     = {wetting_current_cfg_hi_i, wetting_current_cfg_lo_i};
        end else begin
            chg       = (sw_sync ^ q.sw) & q.en;
            next_q.sw = (q.sw & ~q.en) | (sw_sync & q.en);   // see R01
        end
        set_bits = {misc_event_i, chg & q.ien};

        // serial command decode
        if (spi_fall[2]) begin
            next_q.bit_cnt = '0;
            next_q.rd_hit  = 1'b0;
        end else if (!spi_lvl[2] && spi_rise[1] && q.bit_cnt != BC_W'(SMI_CMD_BITS)) begin
            if (q.bit_cnt == '0) begin
                next_q.snap = q.stat;                         // see R11
            end
            next_q.cmd     = {q.cmd[SMI_CMD_BITS-2:0], spi_lvl[0]};
            next_q.bit_cnt = q.bit_cnt + 1'b1;
            if (q.bit_cnt == BC_W'(SMI_CMD_BITS - 1)) begin
                next_q.rd_hit = is_stat_read({q.cmd[SMI_CMD_BITS-2:0], spi_lvl[0]});
            end
        end
        if (spi_rise[2] && q.rd_hit) begin
            rd_done       = 1'b1;
            next_q.rd_hit = 1'b0;
        end
        // a new event wins over the clear in the same cycle
        next_q.stat = (q.stat & ~{(N_IN + 1){rd_done}}) | set_bits; // see R12

        // interrupt line sequencing
        if (!cnt_zero) begin
            next_q.cnt = q.cnt - 1'b1;
        end
        unique case (q.st)
            ST_REL: begin
                if (q.stat != '0) begin
                    next_q.st  = ST_LOW;
                    next_q.cnt = SMI_CNT_W'(ACTIVE_CYC - 1);  // see R22
                end
            end
            ST_LOW: begin
                if (rd_done) begin
                    next_q.st  = ST_HOLD;                     // see R10 R14 R18
                    next_q.cnt = SMI_CNT_W'(IDLE_CYC - 1);
                end else if (q.scheme == SMI_SCHEME_DYNAMIC && cnt_zero) begin
                    next_q.st  = ST_HIGH;                     // see R09 R13
                    next_q.cnt = SMI_CNT_W'(INACTIVE_CYC - 1);
                end
            end
            ST_HIGH: begin
                if (rd_done) begin
                    next_q.st  = ST_HOLD;                     // see R15 R18
                    next_q.cnt = SMI_CNT_W'(IDLE_CYC - 1);
                end else if (cnt_zero) begin
                    next_q.st  = ST_LOW;                      // see R13
                    next_q.cnt = SMI_CNT_W'(ACTIVE_CYC - 1);
                end
            end
            ST_HOLD: begin
                // status cleared here leaves nothing to assert afterwards
                if (cnt_zero) begin
                    next_q.st = ST_REL;                       // see R19 R20
                end
            end
        endcase
        next_q.int_out = 1'b0;
        next_q.int_oe  = (next_q.st == ST_LOW);               // see R08

        // front-end drive
        next_q.wet_on = q.en & {N_IN{run_i}};                 // see R01
        for (int i = 0; i < N_IN; i++) begin
            next_q.wc_out[i*SMI_WC_W +: SMI_WC_W] =
                wc_fix(q.wc[i*SMI_WC_W +: SMI_WC_W]);         // see R06
            next_q.thr_out[i*SMI_TH_W +: SMI_TH_W] =          // see R04
                q.thr[(i / SMI_GRP_SIZE)*SMI_TH_W +: SMI_TH_W];                       // see R03
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;                                          // see R02 R07 R16
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign irq_pin_o.o   = q.int_out;
    assign irq_pin_o.oe  = q.int_oe;
    assign wet_on_o      = q.wet_on;
    assign wet_sel_o     = q.wc_out;
    assign thresh_sel_o  = q.thr_out;
    assign sw_state_o    = q.sw;
    assign int_stat_o    = q.stat;
    assign stat_snap_o   = q.snap;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    function automatic logic wc_all_legal(input logic [N_IN*SMI_WC_W-1:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < N_IN; i++) begin
            if (v[i*SMI_WC_W +: SMI_WC_W] > SMI_WC_15MA) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : wc_all_legal

    AST_EN_OFF_NO_CURRENT: assert property ( // see R01
        1'b1 |=> ((wet_on_o & ~$past(q.en)) == '0))
        else $error("wetting current on for a disabled input");

    AST_RESET_ALL_DISABLED: assert property ( // see R02
        $fell(rst_i) |-> (q.en == '0) && (wet_on_o == '0))
        else $error("inputs enabled right after reset");

    AST_GROUP_THRESH: assert property ( // see R03
        thresh_sel_o[SMI_TH_W-1:0] == thresh_sel_o[(SMI_GRP_SIZE-1)*SMI_TH_W +: SMI_TH_W])
        else $error("inputs of one group carry different thresholds");

    AST_WC_LEGAL: assert property ( // see R06
        wc_all_legal(wet_sel_o))
        else $error("illegal wetting current code driven");

    AST_RESET_WC_ZERO: assert property ( // see R07
        $fell(rst_i) |-> (wet_sel_o == '0) && (q.wc == '0))
        else $error("wetting current not zero after reset");

    AST_OD_LOW_ONLY: assert property ( // see R08
        irq_pin_o.oe |-> !irq_pin_o.o && (q.st == ST_LOW))
        else $error("interrupt line driven other than low");

    AST_STATIC_HOLD: assert property ( // see R10
        irq_pin_o.oe && q.scheme == SMI_SCHEME_STATIC && !rd_done |=> irq_pin_o.oe)
        else $error("static interrupt released without a status read");

    AST_SNAP_FIRST_EDGE: assert property ( // see R11
        !spi_lvl[2] && !spi_fall[2] && spi_rise[1] && q.bit_cnt == '0
        |=> stat_snap_o == $past(q.stat))
        else $error("status not captured on first serial clock edge");

    AST_READ_CLEARS: assert property ( // see R12
        rd_done && set_bits == '0 |=> int_stat_o == '0)
        else $error("status read did not clear the status");

    AST_DYN_RELEASE: assert property ( // see R13
        q.st == ST_LOW && q.scheme == SMI_SCHEME_DYNAMIC && cnt_zero && !rd_done
        |=> !irq_pin_o.oe ##1 !irq_pin_o.oe)
        else $error("dynamic line not released after the active time");

    AST_READ_LOW_RELEASE: assert property ( // see R14
        rd_done && q.st == ST_LOW |=> !irq_pin_o.oe && q.st == ST_HOLD)
        else $error("read while low did not release the line");

    AST_READ_HIGH_STAYS: assert property ( // see R15
        rd_done && q.st == ST_HIGH |=> !irq_pin_o.oe [*2])
        else $error("line driven again after read in the released phase");

    AST_RESET_STATIC: assert property ( // see R16
        $fell(rst_i) |-> q.scheme == SMI_SCHEME_STATIC)
        else $error("scheme not static after reset");

    AST_SCHEME_FROZEN: assert property ( // see R17
        run_i |=> q.scheme == $past(q.scheme))
        else $error("scheme changed while running");

    AST_HOLD_UPDATES: assert property ( // see R19
        q.st == ST_HOLD && !cnt_zero && set_bits[N_IN]
        |=> !irq_pin_o.oe && int_stat_o[N_IN])
        else $error("holdoff event not recorded or line asserted");

    AST_HOLD_READ_QUIET: assert property ( // see R20
        q.st == ST_HOLD && rd_done && set_bits == '0 && misc_event_i == 1'b0
        |=> int_stat_o == '0)
        else $error("read during holdoff left status set");

    COV_STATIC_READ: cover property (
        q.st == ST_LOW && q.scheme == SMI_SCHEME_STATIC && rd_done);

    COV_DYN_TOGGLE: cover property (
        q.st == ST_HIGH ##1 q.st == ST_LOW);

    COV_HIGH_READ: cover property (
        q.st == ST_HIGH && rd_done);

    COV_HOLD_READ: cover property (
        q.st == ST_HOLD && rd_done);

endmodule : smi_irq_pin_ctrl
`default_nettype wire

// ---- verilog/smi_pkg.sv ----
// smi_pkg: shared constants, encodings and carrier types of the switch monitor
// interrupt and input-configuration block.
// assumes: one 20 MHz clock; the spi pins and comparator outputs arrive from outside.
package smi_pkg;

    // ------------------------------------------------------------
    // input array geometry
    // ------------------------------------------------------------
    localparam int SMI_N_IN     = 24;
    localparam int SMI_GRP_SIZE = 4;
    localparam int SMI_TH_W     = 2;
    localparam int SMI_WC_W     = 3;

    // comparator levels: 2V, 2.7V, 3V, 4V
    typedef enum logic [SMI_TH_W-1:0] {
        SMI_TH_2V0,
        SMI_TH_2V7,
        SMI_TH_3V0,
        SMI_TH_4V0
    } smi_thresh_t;

    // wetting current settings, everything above 15 mA is illegal
    typedef enum logic [SMI_WC_W-1:0] {
        SMI_WC_0MA,
        SMI_WC_1MA,
        SMI_WC_2MA,
        SMI_WC_5MA,
        SMI_WC_10MA,
        SMI_WC_15MA
    } smi_wc_t;

    // ------------------------------------------------------------
    // interrupt scheme and serial command
    // ------------------------------------------------------------
    localparam logic SMI_SCHEME_STATIC  = 1'b0;
    localparam logic SMI_SCHEME_DYNAMIC = 1'b1;
    localparam logic SMI_CMD_READ       = 1'b0;
    localparam int   SMI_CMD_BITS       = 7;
    localparam int   SMI_ADDR_W         = 6;
    localparam logic [SMI_ADDR_W-1:0] SMI_STAT_ADDR = 6'h01;

    // ------------------------------------------------------------
    // interrupt timing, in clock cycles
    // ------------------------------------------------------------
    localparam int SMI_CNT_W            = 16;
    localparam int SMI_ACTIVE_CYC_DEF   = 200;
    localparam int SMI_INACTIVE_CYC_DEF = 200;
    localparam int SMI_IDLE_CYC_DEF     = 100;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } smi_spi_t;

    typedef struct packed {
        logic o;
        logic oe;
    } smi_od_pin_t;

endpackage : smi_pkg

// ---- verilog/smi_sync.sv ----
// smi_sync: two-flop synchroniser with a third stage for edge detection.
// assumes: d_i is asynchronous to clk_i; edges come in the same cycle as the level change.
`timescale 1ns/100ps
`default_nettype none
module smi_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // asynchronous input
    input  wire logic [W-1:0] d_i,
    // synchronised level and edges
    output logic      [W-1:0] q_o,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } smi_sync_st_t;

    smi_sync_st_t q;
    smi_sync_st_t next_q;

    always_comb begin
        next_q    = q;
        next_q.s1 = d_i;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // only the second and third stages feed logic
    assign q_o    = q.s2;
    assign rise_o = q.s2 & ~q.s3;
    assign fall_o = ~q.s2 & q.s3;

endmodule : smi_sync
`default_nettype wire

// ---- dv/smi_host_model.sv ----
// smi_host_model: host side of the serial link, issues one 7-bit command per frame.
// assumes: called from the bench at a rising clock edge; the serial clock is slow
// enough that the device samples each phase over four of its own cycles.
`timescale 1ns/100ps
`default_nettype none
module smi_host_model
    import smi_pkg::*;
(
    // bench clock
    input  wire logic         clk_i,
    // serial pins towards the device
    output smi_pkg::smi_spi_t spi_o
);

    initial begin
        spi_o = '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
    end

    // ------------------------------------------------------------
    // one frame: 400 ns serial period, sclk parked low outside frames
    // ------------------------------------------------------------
    task automatic xfer(input logic [6:0] cmd);
        @(posedge clk_i);
        spi_o.cs_n <= 1'b0;
        for (int b = 6; b >= 0; b--) begin
            spi_o.mosi <= cmd[b];
            repeat (4) @(posedge clk_i);
            spi_o.sclk <= 1'b1;
            repeat (4) @(posedge clk_i);
            spi_o.sclk <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        spi_o.cs_n <= 1'b1;
        // released data line must not keep looking valid
        spi_o.mosi <= ~cmd[0];
        repeat (8) @(posedge clk_i);
    endtask : xfer

endmodule : smi_host_model
`default_nettype wire

// ---- dv/testbench.sv ----
// testbench: self-checking bench of the interrupt line and input configuration.
// assumes: smi_host_model plays the serial host; active and inactive times shortened, holdoff lengthened.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module testbench;
    import smi_pkg::*;
    localparam int         ACT     = 150;
    localparam int         INACT   = 150;
    localparam int         IDLE    = 120;
    localparam logic [6:0] RD_STAT = {SMI_CMD_READ, SMI_STAT_ADDR};
    typedef struct packed {
        logic [23:0] en;
        logic [2:0]  wc;
        logic [2:0]  exp_wc;
    } smi_tb_row_t;
    smi_tb_row_t rows [8] = '{'{24'h000001, 3'h0, 3'h0}, '{24'h800000, 3'h1, 3'h1},
        '{24'hffffff, 3'h2, 3'h2}, '{24'h0f0f0f, 3'h3, 3'h3}, '{24'h555555, 3'h4, 3'h4},
        '{24'haaaaaa, 3'h5, 3'h5}, '{24'h000000, 3'h6, 3'h0}, '{24'h123456, 3'h7, 3'h0}};
    logic        clk = 1'b0;
    logic        rst;
    logic        run;
    logic        scheme;
    logic        misc_ev;
    logic [23:0] sw_en;
    logic [23:0] irq_en;
    logic [23:0] sw_in;
    logic [11:0] th_sel;
    logic [35:0] wc_lo;
    logic [35:0] wc_hi;
    smi_spi_t    spi;
    smi_od_pin_t irq_pin;
    logic [23:0] wet_on;
    logic [71:0] wet_sel;
    logic [47:0] th_out;
    logic [23:0] sw_state;
    logic [24:0] int_stat;
    logic [24:0] snap;
    logic [47:0] et;
    logic [71:0] ew;
    int          fails = 0;
    int          checks = 0;
    int          n;

    always #25 clk = ~clk;

    smi_irq_pin_ctrl #(.ACTIVE_CYC(ACT), .INACTIVE_CYC(INACT), .IDLE_CYC(IDLE))
    i_smi_irq_pin_ctrl (.clk_i(clk), .rst_i(rst), .run_i(run), .scheme_i(scheme),
        .switch_en_i(sw_en), .irq_en_i(irq_en), .group_threshold_select_i(th_sel),
        .wetting_current_cfg_lo_i(wc_lo), .wetting_current_cfg_hi_i(wc_hi),
        .switch_input_i(sw_in), .spi_i(spi), .misc_event_i(misc_ev), .irq_pin_o(irq_pin),
        .wet_on_o(wet_on), .wet_sel_o(wet_sel), .thresh_sel_o(th_out),
        .sw_state_o(sw_state), .int_stat_o(int_stat), .stat_snap_o(snap));

    smi_host_model i_smi_host_model (.clk_i(clk), .spi_o(spi));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task automatic pulse_event();
        @(posedge clk);
        misc_ev <= 1'b1;
        @(posedge clk);
        misc_ev <= 1'b0;
    endtask : pulse_event

    // counts settled cycles while the line enable keeps value v, bounded by max
    task automatic run_while(input logic v, input int max);
        n = 0;
        while (irq_pin.oe === v && n < max) begin
            @(negedge clk);
            n++;
        end
    endtask : run_while

    initial begin
        #1000000;
        fails++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        // held running with dynamic requested: reset defaults must win
        {rst, run, scheme, misc_ev} = 4'he;
        {sw_en, irq_en, sw_in} = {24'hffffff, 24'hffffff, 24'h000000};
        {th_sel, wc_lo, wc_hi} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        sw_in <= 24'hffffff;
        repeat (6) @(negedge clk);
        `CHK(irq_pin, 2'b00)
        `CHK(wet_on, 24'h000000)
        `CHK(wet_sel, 72'h0)
        `CHK({sw_state, int_stat}, 49'h0)
        $display("reset test done");
        // static scheme, frozen at reset defaults
        pulse_event();
        run_while(1'b0, 5);
        run_while(1'b1, 300);
        `CHK(n, 300)
        i_smi_host_model.xfer(7'h41);
        i_smi_host_model.xfer(7'h02);
        @(negedge clk);
        `CHK({irq_pin.oe, int_stat[24]}, 2'b11)
        i_smi_host_model.xfer(RD_STAT);
        @(negedge clk);
        `CHK({irq_pin.oe, int_stat, snap[24]}, 27'h1)
        pulse_event();
        @(negedge clk);
        `CHK({irq_pin.oe, int_stat[24]}, 2'b01)
        run_while(1'b0, IDLE);
        `CHK((n > IDLE / 2) && (n < IDLE) && irq_pin.oe === 1'b1, 1'b1)
        i_smi_host_model.xfer(RD_STAT);
        pulse_event();
        i_smi_host_model.xfer(RD_STAT);
        @(negedge clk);
        `CHK(int_stat, 25'h0)
        run_while(1'b0, 2 * IDLE);
        `CHK(n, 2 * IDLE)
        $display("static test done");
        // ------------------------------------------------------------
        // configuration table
        // ------------------------------------------------------------
        @(posedge clk);
        sw_in <= 24'h000000;
        for (int r = 0; r < 8; r++) begin
            @(posedge clk);
            run <= 1'b0;
            sw_en <= rows[r].en;
            wc_lo <= {12{rows[r].wc}};
            wc_hi <= {12{rows[r].wc}};
            for (int g = 0; g < 6; g++) begin
                th_sel[2*g +: 2] <= 2'(r + g);
            end
            repeat (2) @(posedge clk);
            run <= 1'b1;
            repeat (3) @(negedge clk);
            for (int i = 0; i < 24; i++) begin
                et[2*i +: 2] = 2'(r + i / 4);
                ew[3*i +: 3] = rows[r].exp_wc;
            end
            `CHK(wet_on, rows[r].en)
            `CHK(th_out, et)
            `CHK(wet_sel, ew)
        end
        $display("table test done");
        // dynamic scheme, enabled input 0 only
        @(posedge clk);
        run <= 1'b0;
        scheme <= SMI_SCHEME_DYNAMIC;
        sw_en <= 24'h000001;
        th_sel <= 12'hfff; // top level for battery switches
        repeat (2) @(posedge clk);
        run <= 1'b1;
        @(posedge clk);
        scheme <= SMI_SCHEME_STATIC;
        sw_in <= 24'h000002;
        repeat (6) @(negedge clk);
        `CHK(int_stat, 25'h0)
        @(posedge clk);
        sw_in <= 24'h000003;
        @(negedge clk);
        run_while(1'b0, 10);
        `CHK({sw_state[0], int_stat[0]}, 2'b11)
        run_while(1'b1, ACT + 5);
        `CHK(n, ACT)
        run_while(1'b0, INACT + 5);
        `CHK(n, INACT)
        i_smi_host_model.xfer(RD_STAT);
        @(negedge clk);
        `CHK({irq_pin.oe, int_stat}, 26'h0)
        run_while(1'b0, 3 * IDLE);
        `CHK(n, 3 * IDLE)
        $display("dynamic low read test done");
        @(posedge clk);
        sw_in <= 24'h000000;
        @(negedge clk);
        run_while(1'b0, 10);
        run_while(1'b1, ACT + 5);
        i_smi_host_model.xfer(RD_STAT);
        @(negedge clk);
        `CHK(int_stat, 25'h0)
        run_while(1'b0, 3 * IDLE);
        `CHK(n, 3 * IDLE)
        $display("dynamic high read test done");
        // reset in mid-run while the line is pulled low, config frozen by run
        pulse_event();
        repeat (3) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK({irq_pin, wet_on, int_stat}, 51'h0)
        `CHK(wet_sel, 72'h0)
        $display("mid-run reset test done");
        conclude();
    end

endmodule : testbench
`default_nettype wire
